// File: core/cfo_alu.sv
// combinational result, carry and zero for the file operations
`timescale 1ns/1ps
module cfo_alu (
    input wire cfo_pkg::cfo_op_e op_i,
    input wire logic [cfo_pkg::DATA_W-1:0] acc_i,
    input wire logic [cfo_pkg::DATA_W-1:0] file_i,
    output logic [cfo_pkg::DATA_W-1:0] res_o,
    output logic carry_o,
    output logic carry_upd_o,
    output logic zero_o
);
    import cfo_pkg::*;

    always_comb begin
        res_o = file_i;
        carry_o = 1'b0;
        carry_upd_o = 1'b0;
        case (op_i)
            CFO_OP_INC: begin
                res_o = file_i + DATA_ONE;
            end
            CFO_OP_OR: begin
                res_o = acc_i | file_i;
            end
            CFO_OP_SHL: begin
                res_o = {file_i[DATA_W-2:0], 1'b0};
                carry_o = file_i[DATA_W-1];
                carry_upd_o = 1'b1;
            end
            CFO_OP_SHR: begin
                res_o = {1'b0, file_i[DATA_W-1:1]};
                carry_o = file_i[0];
                carry_upd_o = 1'b1;
            end
            default: begin
                res_o = file_i;
            end
        endcase
        zero_o = (res_o == DATA_ZERO);
    end
endmodule

// File: core/cfo_core.sv
// file-register and indirect-load execution datapath
`timescale 1ns/1ps
module cfo_core (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire cfo_pkg::cfo_req_s req_i,
    output logic ready_o,
    output logic done_o,
    input wire logic acc_load_i,
    input wire logic [cfo_pkg::DATA_W-1:0] acc_load_val_i,
    input wire logic ptr_load_i,
    input wire logic ptr_load_sel_i,
    input wire logic [cfo_pkg::ADDR_W-1:0] ptr_load_val_i,
    output cfo_pkg::cfo_mem_s mem_o,
    output logic mem_re_o,
    input wire logic [cfo_pkg::DATA_W-1:0] mem_rdata_i,
    output logic [cfo_pkg::DATA_W-1:0] acc_o,
    output logic carry_o,
    output logic zero_o,
    output logic [cfo_pkg::ADDR_W-1:0] ptr0_o,
    output logic [cfo_pkg::ADDR_W-1:0] ptr1_o
);
    import cfo_pkg::*;

    typedef struct packed {
        cfo_state_e state;
        cfo_req_s req;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic zero;
        cfo_mem_s mem;
        logic done;
    } cfo_core_st_s;

    cfo_core_st_s st;
    cfo_core_st_s next_st;

    logic accept;
    logic [ADDR_W-1:0] ptr0;
    logic [ADDR_W-1:0] ptr1;
    logic [ADDR_W-1:0] sel_ptr;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] cur_ptr;
    logic step_any;
    logic step0;
    logic step1;
    logic load0;
    logic load1;
    logic [DATA_W-1:0] alu_res;
    logic alu_carry;
    logic alu_carry_upd;
    logic alu_zero;
    logic to_acc;

    assign accept = (st.state == CFO_IDLE) && op_valid_i;
    assign sel_ptr = req_i.ptr_sel ? ptr1 : ptr0;
    assign cur_ptr = st.req.ptr_sel ? ptr1 : ptr0;

    // effective address of the request being taken
    always_comb begin
        ea = {{(ADDR_W-FADDR_W){1'b0}}, req_i.faddr};
        if (req_i.op == CFO_OP_LOAD) begin
            if (req_i.rel) begin
                ea = sel_ptr + {{(ADDR_W-OFF_W){req_i.offset[OFF_W-1]}}, req_i.offset};
            end else begin
                case (req_i.mode)
                    CFO_PRE_INC: ea = sel_ptr + PTR_ONE;
                    CFO_PRE_DEC: ea = sel_ptr - PTR_ONE;
                    default: ea = sel_ptr;
                endcase
            end
        end else if (req_i.faddr == IND0_FADDR) begin
            ea = ptr0;
        end else if (req_i.faddr == IND1_FADDR) begin
            ea = ptr1;
        end
    end

    // pointer adjusts once per non-relative indirect load, at the accept edge; the
    // address for post modes is latched before the step lands
    assign step_any = accept && (req_i.op == CFO_OP_LOAD) && !req_i.rel;
    assign step0 = step_any && !req_i.ptr_sel;
    assign step1 = step_any && req_i.ptr_sel;
    assign load0 = ptr_load_i && !ptr_load_sel_i;
    assign load1 = ptr_load_i && ptr_load_sel_i;

    cfo_ptr #(
        .WIDTH(ADDR_W)
    ) u_ptr0 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load0),
        .load_val_i(ptr_load_val_i),
        .step_i(step0),
        .down_i(req_i.mode[0]),
        .ptr_o(ptr0)
    );

    cfo_ptr #(
        .WIDTH(ADDR_W)
    ) u_ptr1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load1),
        .load_val_i(ptr_load_val_i),
        .step_i(step1),
        .down_i(req_i.mode[0]),
        .ptr_o(ptr1)
    );

    cfo_alu u_alu (
        .op_i(st.req.op),
        .acc_i(st.acc),
        .file_i(mem_rdata_i),
        .res_o(alu_res),
        .carry_o(alu_carry),
        .carry_upd_o(alu_carry_upd),
        .zero_o(alu_zero)
    );

    assign to_acc = (st.req.op == CFO_OP_LOAD) || (st.req.dest == DEST_ACC);

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.mem.we = 1'b0;
        case (st.state)
            CFO_IDLE: begin
                if (op_valid_i) begin
                    next_st.req = req_i;
                    next_st.mem.addr = ea;
                    next_st.state = CFO_READ;
                end else if (acc_load_i) begin
                    next_st.acc = acc_load_val_i;
                end
            end
            CFO_READ: begin
                if (to_acc) begin
                    next_st.acc = alu_res;
                    next_st.state = CFO_IDLE;
                    next_st.done = 1'b1;
                end else begin
                    next_st.mem.wdata = alu_res;
                    next_st.mem.we = 1'b1;
                    next_st.state = CFO_WRITE;
                end
                // carry only moves for shifts; pointer steps never touch flags
                if (alu_carry_upd) begin
                    next_st.carry = alu_carry;
                end
                next_st.zero = alu_zero;
            end
            CFO_WRITE: begin
                next_st.state = CFO_IDLE;
                next_st.done = 1'b1;
            end
            default: begin
                next_st.state = CFO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.state <= CFO_IDLE;
            st.req <= '0;
            st.acc <= ACC_RST;
            st.carry <= CARRY_RST;
            st.zero <= ZERO_RST;
            st.mem <= '0;
            st.done <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign ready_o = (st.state == CFO_IDLE);
    assign mem_re_o = (st.state == CFO_READ);
    assign done_o = st.done;
    assign mem_o = st.mem;
    assign acc_o = st.acc;
    assign carry_o = st.carry;
    assign zero_o = st.zero;
    assign ptr0_o = ptr0;
    assign ptr1_o = ptr1;

    dest_acc_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && to_acc
        |=> acc_o == $past(alu_res) && !mem_o.we && done_o
    ) else $error("accumulator destination not written");

    dest_file_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && !to_acc
        |=> mem_o.we && mem_o.wdata == $past(alu_res) && acc_o == $past(acc_o)
            ##1 done_o && !mem_o.we
    ) else $error("file destination not written back");

    inc_flags_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_INC)
        |-> alu_res == mem_rdata_i + DATA_ONE ##1 carry_o == $past(carry_o)
    ) else $error("add one wrong or carry disturbed");

    or_value_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_OR)
        |-> alu_res == (acc_o | mem_rdata_i)
    ) else $error("or result wrong");

    shl_carry_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_SHL)
        |=> carry_o == $past(mem_rdata_i[DATA_W-1])
            && $past(alu_res) == {$past(mem_rdata_i[DATA_W-2:0]), 1'b0}
    ) else $error("left shift carry or result wrong");

    shr_carry_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_SHR)
        |=> carry_o == $past(mem_rdata_i[0])
            && $past(alu_res) == {1'b0, $past(mem_rdata_i[DATA_W-1:1])}
    ) else $error("right shift carry or result wrong");

    zero_flag_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) |=> zero_o == ($past(alu_res) == DATA_ZERO)
    ) else $error("zero flag does not match result");

    redirect_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op != CFO_OP_LOAD) && (req_i.faddr == IND1_FADDR)
        |=> mem_o.addr == $past(ptr1)
    ) else $error("indirect target not redirected");

    pre_dec_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD) && !req_i.rel && (req_i.mode == CFO_PRE_DEC)
        |=> mem_o.addr == $past(sel_ptr) - PTR_ONE && cur_ptr == mem_o.addr
    ) else $error("pre-decrement address wrong");

    post_inc_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD) && !req_i.rel && (req_i.mode == CFO_POST_INC)
        |=> mem_o.addr == $past(sel_ptr) && cur_ptr == $past(sel_ptr) + PTR_ONE
    ) else $error("post-increment sequence wrong");

    rel_keep_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD) && req_i.rel && !ptr_load_i
        |=> mem_o.addr == $past(sel_ptr)
            + {{(ADDR_W-OFF_W){$past(req_i.offset[OFF_W-1])}}, $past(req_i.offset)}
            && cur_ptr == $past(sel_ptr)
    ) else $error("relative load moved pointer or wrong address");

    load_flags_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD)
        |=> carry_o == $past(carry_o) ##1 carry_o == $past(carry_o, 2) && acc_o == $past(alu_res)
    ) else $error("indirect load disturbed carry");

    redirect_zero_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op != CFO_OP_LOAD) && (req_i.faddr == IND0_FADDR)
        |=> mem_o.addr == $past(ptr0)
    ) else $error("first indirect target not redirected");

    pre_inc_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD) && !req_i.rel && (req_i.mode == CFO_PRE_INC)
        |=> mem_o.addr == $past(sel_ptr) + PTR_ONE && cur_ptr == mem_o.addr
    ) else $error("pre-increment address wrong");

    post_dec_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        accept && (req_i.op == CFO_OP_LOAD) && !req_i.rel && (req_i.mode == CFO_POST_DEC)
        |=> mem_o.addr == $past(sel_ptr) && cur_ptr == $past(sel_ptr) - PTR_ONE
    ) else $error("post-decrement sequence wrong");

    move_value_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_MOVE)
        |-> alu_res == mem_rdata_i && !alu_carry_upd
    ) else $error("move result wrong or carry touched");

    load_dest_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.state == CFO_READ) && (st.req.op == CFO_OP_LOAD)
        |=> acc_o == $past(mem_rdata_i) && done_o && !mem_o.we
    ) else $error("indirect load did not reach accumulator");
endmodule

// File: core/cfo_ptr.sv
// one indirect pointer with load and wrapping step
`timescale 1ns/1ps
module cfo_ptr #(
    parameter int WIDTH = cfo_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_val_i,
    input wire logic step_i,
    input wire logic down_i,
    output logic [WIDTH-1:0] ptr_o
);
    import cfo_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } cfo_ptr_st_s;

    cfo_ptr_st_s st;
    cfo_ptr_st_s next_st;

    always_comb begin
        next_st = st;
        // a step beats a load in the same cycle
        if (step_i) begin
            if (down_i) begin
                next_st.value = st.value - WIDTH'(PTR_ONE);
            end else begin
                next_st.value = st.value + WIDTH'(PTR_ONE);
            end
        end else if (load_i) begin
            next_st.value = load_val_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.value <= WIDTH'(PTR_RST);
        end else begin
            st <= next_st;
        end
    end

    assign ptr_o = st.value;

    ptr_wrap_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        step_i |=> ptr_o == ($past(down_i) ? $past(ptr_o) - WIDTH'(PTR_ONE)
                                    : $past(ptr_o) + WIDTH'(PTR_ONE))
    ) else $error("pointer step did not wrap by one");
endmodule

// File: shared/cfo_pkg.sv
// constants, types and carriers shared by the core file-operation datapath
package cfo_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int FADDR_W = 7;
    localparam int OFF_W = 6;

    // file addresses that stand for the two indirect targets
    localparam logic [FADDR_W-1:0] IND0_FADDR = 7'h00;
    localparam logic [FADDR_W-1:0] IND1_FADDR = 7'h01;

    localparam logic [ADDR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] PTR_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic CARRY_RST = 1'b0;
    localparam logic ZERO_RST = 1'b0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        CFO_OP_INC = 3'b000,
        CFO_OP_OR = 3'b001,
        CFO_OP_SHL = 3'b010,
        CFO_OP_SHR = 3'b011,
        CFO_OP_MOVE = 3'b100,
        CFO_OP_LOAD = 3'b101
    } cfo_op_e;

    typedef enum logic [1:0] {
        CFO_PRE_INC = 2'b00,
        CFO_PRE_DEC = 2'b01,
        CFO_POST_INC = 2'b10,
        CFO_POST_DEC = 2'b11
    } cfo_mode_e;

    typedef enum logic [1:0] {
        CFO_IDLE = 2'b00,
        CFO_READ = 2'b01,
        CFO_WRITE = 2'b10
    } cfo_state_e;

    typedef struct packed {
        cfo_op_e op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic ptr_sel;
        cfo_mode_e mode;
        logic rel;
        logic [OFF_W-1:0] offset;
    } cfo_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
    } cfo_mem_s;
endpackage

// File: testbench/tb_core_file_op_execution.sv
// self-checking bench for the file-operation and indirect-load datapath
`timescale 1ns/1ps
module tb_core_file_op_execution;
    import cfo_pkg::*;
    typedef struct packed {
        cfo_op_e op;
        logic [6:0] fa;
        logic d;
        logic [7:0] acc;
        logic [7:0] fv;
        logic [7:0] res;
        logic c;
    } cfo_row_s;
    logic clk_i;
    logic rst_n_i;
    logic op_valid_i;
    cfo_req_s req_i;
    logic ready_o;
    logic done_o;
    logic acc_load_i;
    logic [7:0] acc_load_val_i;
    logic ptr_load_i;
    logic ptr_load_sel_i;
    logic [15:0] ptr_load_val_i;
    cfo_mem_s mem_o;
    logic mem_re_o;
    logic [7:0] mem_rdata_i;
    logic [7:0] acc_o;
    logic carry_o;
    logic zero_o;
    logic [15:0] ptr0_o;
    logic [15:0] ptr1_o;
    logic [7:0] mem [0:65535];
    logic [15:0] raddr;
    int wcount = 0;
    int err_count = 0;
    int cmp_count = 0;
    cfo_row_s rows [13];
    cfo_mode_e mt [4];
    logic [15:0] eat [4];
    logic [15:0] ptt [4];
    int w0;

    cfo_core i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .req_i(req_i),
        .ready_o(ready_o), .done_o(done_o), .acc_load_i(acc_load_i),
        .acc_load_val_i(acc_load_val_i), .ptr_load_i(ptr_load_i),
        .ptr_load_sel_i(ptr_load_sel_i), .ptr_load_val_i(ptr_load_val_i), .mem_o(mem_o),
        .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i), .acc_o(acc_o), .carry_o(carry_o),
        .zero_o(zero_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o));

    // read data only meaningful in the read cycle; otherwise show a wrong value
    assign mem_rdata_i = mem_re_o ? mem[mem_o.addr] : ~mem[mem_o.addr];

    always @(posedge clk_i) begin
        if (mem_re_o === 1'b1) begin
            raddr <= mem_o.addr;
        end
        if (mem_o.we === 1'b1) begin
            mem[mem_o.addr] <= mem_o.wdata;
            wcount <= wcount + 1;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic cfo_req_s mk(cfo_op_e op, logic [6:0] fa, logic d, logic sel,
                                    cfo_mode_e m, logic rel, logic [5:0] off);
        cfo_req_s r;
        r = '0;
        r.op = op;
        r.faddr = fa;
        r.dest = d;
        r.ptr_sel = sel;
        r.mode = m;
        r.rel = rel;
        r.offset = off;
        return r;
    endfunction

    // the op is taken at the edge after it is driven, since the core sits idle
    task automatic run(input cfo_req_s r, input int lat);
        int n;
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        // n counts edges from the accept edge, which has just passed
        for (n = 2; n <= 7; n++) begin
            @(posedge clk_i);
            #1;
            if (done_o === 1'b1) begin
                break;
            end
        end
        chk(16'(n), 16'(lat));
        if (n > 7) begin
            end_of_test();
        end
    endtask

    task automatic set_acc(input logic [7:0] v);
        @(posedge clk_i);
        acc_load_i <= 1'b1;
        acc_load_val_i <= v;
        @(posedge clk_i);
        acc_load_i <= 1'b0;
    endtask

    task automatic set_ptr(input logic sel, input logic [15:0] v);
        @(posedge clk_i);
        ptr_load_i <= 1'b1;
        ptr_load_sel_i <= sel;
        ptr_load_val_i <= v;
        @(posedge clk_i);
        ptr_load_i <= 1'b0;
    endtask

    // one indirect load and its checks; carry must survive every load
    task automatic load(input logic sel, input cfo_mode_e m, input logic rel,
                        input logic [5:0] off, input logic [15:0] ea, input logic [15:0] p);
        run(mk(CFO_OP_LOAD, 7'h00, 1'b1, sel, m, rel, off), 2);
        chk(raddr, ea);
        chk(sel ? ptr1_o : ptr0_o, p);
        chk(16'(acc_o), 16'(mem[ea]));
        chk(16'(zero_o), 16'(mem[ea] == 8'h00));
        chk(16'(carry_o), 16'h0001);
    endtask

    initial begin
        rst_n_i = 1'b0;
        op_valid_i = 1'b0;
        req_i = '0;
        acc_load_i = 1'b0;
        acc_load_val_i = 8'h00;
        ptr_load_i = 1'b0;
        ptr_load_sel_i = 1'b0;
        ptr_load_val_i = 16'h0000;
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) + 8'(a >> 8) + 8'h11;
        end
        rows = '{
            '{CFO_OP_INC, 7'h20, 1'b0, 8'h00, 8'hff, 8'h00, 1'b0},
            '{CFO_OP_INC, 7'h21, 1'b1, 8'h33, 8'h7f, 8'h80, 1'b0},
            '{CFO_OP_OR, 7'h22, 1'b0, 8'h0f, 8'hf0, 8'hff, 1'b0},
            '{CFO_OP_OR, 7'h23, 1'b1, 8'h00, 8'h00, 8'h00, 1'b0},
            '{CFO_OP_SHL, 7'h24, 1'b0, 8'h00, 8'h81, 8'h02, 1'b1},
            '{CFO_OP_INC, 7'h25, 1'b0, 8'h11, 8'hff, 8'h00, 1'b1},
            '{CFO_OP_SHR, 7'h26, 1'b1, 8'h44, 8'h01, 8'h00, 1'b1},
            '{CFO_OP_SHL, 7'h27, 1'b0, 8'h00, 8'h40, 8'h80, 1'b0},
            '{CFO_OP_SHR, 7'h28, 1'b0, 8'h00, 8'hfe, 8'h7f, 1'b0},
            '{CFO_OP_MOVE, 7'h29, 1'b1, 8'h55, 8'h00, 8'h00, 1'b0},
            '{CFO_OP_SHL, 7'h2a, 1'b1, 8'h66, 8'h80, 8'h00, 1'b1},
            '{CFO_OP_MOVE, 7'h2b, 1'b0, 8'h00, 8'h5a, 8'h5a, 1'b1},
            '{CFO_OP_INC, 7'h7f, 1'b1, 8'h77, 8'h41, 8'h42, 1'b1}};
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk({ready_o, done_o, mem_re_o, carry_o, zero_o, acc_o}, 16'h1000);
        chk(ptr0_o | ptr1_o, 16'h0000);
        foreach (rows[i]) begin
            mem[{9'h000, rows[i].fa}] = rows[i].fv;
            set_acc(rows[i].acc);
            w0 = wcount;
            run(mk(rows[i].op, rows[i].fa, rows[i].d, 1'b0, CFO_PRE_INC, 1'b0, 6'h00),
                rows[i].d ? 3 : 2);
            chk(16'(acc_o), 16'(rows[i].d ? rows[i].acc : rows[i].res));
            chk(16'(mem[{9'h000, rows[i].fa}]), 16'(rows[i].d ? rows[i].res : rows[i].fv));
            chk(16'(wcount - w0), 16'(rows[i].d));
            chk(raddr, {9'h000, rows[i].fa});
            chk(16'(zero_o), 16'(rows[i].res == 8'h00));
            chk(16'(carry_o), 16'(rows[i].c));
        end
        // all four step modes, walked across the 0000h/ffffh boundary
        mt = '{CFO_PRE_DEC, CFO_POST_INC, CFO_POST_DEC, CFO_PRE_INC};
        eat = '{16'hffff, 16'hffff, 16'h0000, 16'h0000};
        ptt = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};
        set_ptr(1'b1, 16'h0000);
        foreach (mt[i]) begin
            load(1'b1, mt[i], 1'b0, 6'h00, eat[i], ptt[i]);
        end
        set_ptr(1'b0, 16'h0010);
        mem[16'hfff0] = 8'h00;
        load(1'b0, CFO_PRE_INC, 1'b1, 6'h20, 16'hfff0, 16'h0010);
        load(1'b0, CFO_POST_DEC, 1'b1, 6'h1f, 16'h002f, 16'h0010);
        chk(ptr1_o, 16'h0000);
        // indirect targets redirect a plain file op to the pointed location
        set_ptr(1'b1, 16'h1234);
        mem[16'h1234] = 8'hff;
        run(mk(CFO_OP_INC, IND1_FADDR, 1'b1, 1'b0, CFO_PRE_INC, 1'b0, 6'h00), 3);
        chk(raddr, 16'h1234);
        chk(16'(mem[16'h1234]), 16'h0000);
        chk(ptr1_o, 16'h1234);
        chk(16'(zero_o), 16'h0001);
        run(mk(CFO_OP_MOVE, IND0_FADDR, 1'b0, 1'b0, CFO_PRE_INC, 1'b0, 6'h00), 2);
        chk(16'(acc_o), 16'h0021);
        chk(16'(zero_o), 16'h0000);
        // reset in mid-run brings everything back at once
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        #1;
        chk({ready_o, done_o, mem_re_o, carry_o, zero_o, acc_o}, 16'h1000);
        chk(ptr0_o | ptr1_o, 16'h0000);
        // first request straight after the second release
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        run(mk(CFO_OP_MOVE, IND0_FADDR, 1'b0, 1'b0, CFO_PRE_INC, 1'b0, 6'h00), 2);
        chk(16'(acc_o), 16'h0011);
        chk(16'(zero_o), 16'h0000);
        end_of_test();
    end
endmodule
